/* File: logic/ssc_pkg.sv */
// Constants and types for the sleep control and group-seven event block.
// Assumes an APB master on pclk and a 32 kHz real-time clock on a pin.
package ssc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_SLEEP_CTRL = 10'h061;
   localparam logic [9:0] IDX_STS_SEVEN = 10'h064;
   localparam logic [9:0] IDX_EN_SEVEN = 10'h066;
   localparam logic [9:0] IDX_SUPPLY_CTRL = 10'h070;
   localparam logic [9:0] IDX_INT_STS = 10'h071;
   localparam logic [9:0] IDX_INT_MASK = 10'h072;
   localparam int ADDR_W = 12;
   // Field positions
   localparam int SLP_TYPE_LSB = 2;
   localparam int SLP_TYPE_MSB = 4;
   localparam int SLP_TRIG_BIT = 5;
   localparam int SLP_FLAG_BIT = 5;
   localparam int REDIRECT_BIT = 0;
   localparam int INT_TRIG_BIT = 0;
   localparam int INT_OFF_BIT = 1;
   localparam int EV_PINS = 5;
   localparam int EV_BITS = 6;
   // Sleep type codes for the two deepest states
   localparam logic [2:0] SLP_TYPE_S4 = 3'h6;
   localparam logic [2:0] SLP_TYPE_S5 = 3'h7;
   // Reset values
   localparam logic [2:0] RST_SLP_TYPE = 3'h0;
   localparam logic [5:0] RST_STS_SEVEN = 6'h00;
   localparam logic [5:0] RST_EN_SEVEN = 6'h00;
   localparam logic [1:0] RST_INT = 2'h0;
   // RTC edges counted before going off; second edge lands 1 to 2 periods on
   localparam logic [1:0] RTC_EDGES_M1 = 2'h1;
   // Timing: 32 kHz clock period and pclk period
   localparam int RTC_PERIOD_NS = 31250;
   localparam int PCLK_PERIOD_NS = 100;
   localparam int RTC_MIN_CYC = (RTC_PERIOD_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
   localparam int RTC_MAX_CYC = (2 * RTC_PERIOD_NS) / PCLK_PERIOD_NS;

   typedef enum logic [1:0] {SS_RUN, SS_WAIT, SS_OFF} ssc_fsm_type;

   // Whole state of the block
   typedef struct packed {
      ssc_fsm_type fsm;
      logic [1:0] rtc_cnt;
      logic [2:0] rtc_sync;
      logic [EV_PINS-1:0] ev_s1;
      logic [EV_PINS-1:0] ev_s2;
      logic [EV_PINS-1:0] ev_s3;
      logic [2:0] slp_type;
      logic redirect;
      logic [EV_BITS-1:0] sts7;
      logic [EV_BITS-1:0] en7;
      logic [1:0] int_sts;
      logic [1:0] int_mask;
      logic redir_pend;
      logic ps_on_oe;
      logic evt_n;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ssc_state_type;
endpackage

/* File: logic/ssc_top.sv */
// Sleep control, supply-on release and group-seven event status, APB slave.
// Assumes pclk at 10 MHz, a free-running 32 kHz RTC clock pin and
// asynchronous event pins; both are synchronised here.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module ssc_top
   import ssc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic rtc_clk_in,
   input wire logic gpio_event_in0,
   input wire logic gpio_event_in1,
   input wire logic gpio_event_in2,
   input wire logic gpio_event_in3,
   input wire logic keyboard_port_event_in,
   output logic power_supply_on_n_out,
   output logic power_supply_on_n_oe,
   output logic group_event_out_n,
   output logic irq
);
   ssc_state_type s_reg;
   ssc_state_type s_next;
   logic setup;
   logic access;
   logic wr;
   logic rd;
   logic trig;
   logic deep;
   logic rtc_rise;
   logic [EV_PINS-1:0] ev_rise;
   logic [ADDR_W-1:0] ad_ctrl;
   logic [ADDR_W-1:0] ad_sts;
   logic [ADDR_W-1:0] ad_en;
   logic [ADDR_W-1:0] ad_sup;
   logic [ADDR_W-1:0] ad_ists;
   logic [ADDR_W-1:0] ad_imask;

   // Byte addresses of the word-aligned registers
   assign ad_ctrl = {IDX_SLEEP_CTRL, 2'b00};
   assign ad_sts = {IDX_STS_SEVEN, 2'b00};
   assign ad_en = {IDX_EN_SEVEN, 2'b00};
   assign ad_sup = {IDX_SUPPLY_CTRL, 2'b00};
   assign ad_ists = {IDX_INT_STS, 2'b00};
   assign ad_imask = {IDX_INT_MASK, 2'b00};

   // Bus phase decode; writes land only at the completing edge
   assign setup = psel & ~penable;
   assign access = psel & penable & s_reg.pready;
   assign wr = access & pwrite & pstrb[0];
   assign rd = access & ~pwrite;
   // Only a one in the trigger bit counts; a zero write is inert
   assign trig = wr & (paddr == ad_ctrl) & pwdata[SLP_TRIG_BIT];
   // Type written together with the trigger is the one acted on
   assign deep = (pwdata[SLP_TYPE_MSB:SLP_TYPE_LSB] == SLP_TYPE_S4) |
                 (pwdata[SLP_TYPE_MSB:SLP_TYPE_LSB] == SLP_TYPE_S5);
   // Edge detectors look only past the first sync stage
   assign rtc_rise = s_reg.rtc_sync[1] & ~s_reg.rtc_sync[2];
   assign ev_rise = s_reg.ev_s2 & ~s_reg.ev_s3;

   // Next-state logic for the whole block
   always_comb begin
      s_next = s_reg;
      s_next.rtc_sync = {s_reg.rtc_sync[1:0], rtc_clk_in};
      s_next.ev_s1 = {keyboard_port_event_in, gpio_event_in3, gpio_event_in2,
                      gpio_event_in1, gpio_event_in0};
      s_next.ev_s2 = s_reg.ev_s1;
      s_next.ev_s3 = s_reg.ev_s2;
      s_next.pready = setup;
      s_next.pslverr = 1'b0;
      // Register writes; clears are applied before sets so sets win
      if (wr) begin
         unique case (paddr)
            ad_ctrl: begin
               // Only the type field is stored; other bits dropped
               s_next.slp_type = pwdata[SLP_TYPE_MSB:SLP_TYPE_LSB];
            end
            ad_sts: begin
               s_next.sts7 = s_reg.sts7 & ~pwdata[EV_BITS-1:0];
               if (pwdata[SLP_FLAG_BIT]) begin
                  s_next.redir_pend = 1'b0;
               end
            end
            ad_en: s_next.en7 = pwdata[EV_BITS-1:0];
            ad_sup: s_next.redirect = pwdata[REDIRECT_BIT];
            ad_imask: s_next.int_mask = pwdata[1:0];
            default: ;
         endcase
      end
      // Reading interrupt status clears just the bits that were returned
      if (rd && paddr == ad_ists) begin
         s_next.int_sts = s_reg.int_sts & ~s_reg.prdata[1:0];
      end
      // Pin events latch on rising edges
      s_next.sts7[EV_PINS-1:0] = s_next.sts7[EV_PINS-1:0] | ev_rise;
      // Sleep power sequence
      unique case (s_reg.fsm)
         SS_RUN: begin
            if (trig && !s_reg.redirect && deep) begin
               s_next.fsm = SS_WAIT;
               s_next.rtc_cnt = 2'h0;
            end
         end
         SS_WAIT: begin
            // Second synced RTC edge is 1..2 periods after the write
            if (rtc_rise) begin
               s_next.rtc_cnt = s_reg.rtc_cnt + 2'h1;
               if (s_reg.rtc_cnt == RTC_EDGES_M1) begin
                  s_next.fsm = SS_OFF;
                  s_next.ps_on_oe = 1'b1;
                  s_next.int_sts[INT_OFF_BIT] = 1'b1;
               end
            end
         end
         SS_OFF: begin
            // Supply gone; only a reset brings the block back
            s_next.ps_on_oe = 1'b1;
         end
         // Unused state code falls back to run
         default: s_next.fsm = SS_RUN;
      endcase
      // Every trigger write flags, redirected or not
      if (trig) begin
         s_next.sts7[SLP_FLAG_BIT] = 1'b1;
         s_next.int_sts[INT_TRIG_BIT] = 1'b1;
         if (s_reg.redirect) begin
            s_next.redir_pend = 1'b1;
         end
      end
      // Redirected trigger forces the event out regardless of enable
      s_next.evt_n = ~(|(s_next.sts7 & s_next.en7) | s_next.redir_pend);
      s_next.irq = |(s_next.int_sts & s_next.int_mask);
      // Read data prepared in setup so it leaves a flop
      s_next.prdata = 32'h0000_0000;
      if (setup) begin
         unique case (paddr)
            // Trigger and reserved bits read back zero
            ad_ctrl: s_next.prdata = {27'h0, s_reg.slp_type, 2'h0};
            ad_sts: s_next.prdata = {26'h0, s_reg.sts7};
            ad_en: s_next.prdata = {26'h0, s_reg.en7};
            ad_sup: s_next.prdata = {31'h0, s_reg.redirect};
            ad_ists: s_next.prdata = {30'h0, s_reg.int_sts};
            ad_imask: s_next.prdata = {30'h0, s_reg.int_mask};
            default: s_next.pslverr = 1'b1;
         endcase
      end
   end

   // State register; both power-on resets map to presetn
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg.fsm <= SS_RUN;
         s_reg.rtc_cnt <= 2'h0;
         s_reg.rtc_sync <= 3'h0;
         s_reg.ev_s1 <= 5'h00;
         s_reg.ev_s2 <= 5'h00;
         s_reg.ev_s3 <= 5'h00;
         s_reg.slp_type <= RST_SLP_TYPE;
         s_reg.redirect <= 1'b0;
         s_reg.sts7 <= RST_STS_SEVEN;
         s_reg.en7 <= RST_EN_SEVEN;
         s_reg.int_sts <= RST_INT;
         s_reg.int_mask <= RST_INT;
         s_reg.redir_pend <= 1'b0;
         s_reg.ps_on_oe <= 1'b0;
         s_reg.evt_n <= 1'b1;
         s_reg.irq <= 1'b0;
         s_reg.pready <= 1'b0;
         s_reg.pslverr <= 1'b0;
         s_reg.prdata <= 32'h0000_0000;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state flops
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign prdata = s_reg.prdata;
   // Supply pin only ever pulls low; floating means off
   assign power_supply_on_n_out = 1'b0;
   assign power_supply_on_n_oe = s_reg.ps_on_oe;
   assign group_event_out_n = s_reg.evt_n;
   assign irq = s_reg.irq;

   // Checks on the design's own behaviour
   // Longest legal wait: two RTC periods plus sync and slack
   localparam int WAIT_MAX_CYC = 640;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ctrl_low_zero: assert property (
      pready && psel && !pwrite && paddr == ad_ctrl |-> prdata[1:0] == 2'h0)
      else $error("control low bits not zero");
   a_type_store: assert property (
      wr && paddr == ad_ctrl |=> s_reg.slp_type == $past(pwdata[4:2]))
      else $error("sleep type not stored");
   a_deep_wait: assert property (
      s_reg.fsm == SS_RUN && trig && deep && !s_reg.redirect |=> s_reg.fsm == SS_WAIT)
      else $error("deep trigger did not start wait");
   a_off_float: assert property (
      s_reg.fsm == SS_OFF |-> power_supply_on_n_oe)
      else $error("supply-on driven in off state");
   a_second_edge: assert property (
      s_reg.fsm == SS_WAIT && rtc_rise && s_reg.rtc_cnt == 2'h1 |=> s_reg.fsm == SS_OFF)
      else $error("off not entered on second rtc edge");
   a_no_early_off: assert property (
      s_reg.fsm == SS_WAIT && s_reg.rtc_cnt == 2'h0 |=> s_reg.fsm != SS_OFF)
      else $error("off entered before second rtc edge");
   a_shallow_none: assert property (
      s_reg.fsm == SS_RUN && trig && !deep |=> s_reg.fsm == SS_RUN && !s_reg.ps_on_oe)
      else $error("shallow type acted");
   a_trig_reads_zero: assert property (
      pready && psel && !pwrite && paddr == ad_ctrl |-> prdata[31:5] == 27'h0)
      else $error("trigger or upper bits read nonzero");
   a_redirect_evt: assert property (
      s_reg.fsm == SS_RUN && trig && s_reg.redirect |=> s_reg.fsm == SS_RUN ##0
      s_reg.redir_pend ##0 !group_event_out_n)
      else $error("redirect did not raise event");
   a_flag_set: assert property (
      trig |=> s_reg.sts7[5])
      else $error("sleep-write flag not set");
   a_zero_inert: assert property (
      wr && paddr == ad_ctrl && !pwdata[5] && s_reg.fsm == SS_RUN && !s_reg.sts7[5]
      |=> s_reg.fsm == SS_RUN && !s_reg.sts7[5])
      else $error("zero trigger write acted");
   a_w1c_clear: assert property (
      wr && paddr == ad_sts && pwdata[0] && !ev_rise[0] |=> !s_reg.sts7[0])
      else $error("status bit not cleared by one");
   a_pin_latch: assert property (
      ev_rise[4] |=> s_reg.sts7[4])
      else $error("keyboard event not latched");
   a_evt_gate: assert property (
      !s_reg.redir_pend && (s_reg.sts7 & s_reg.en7) == 6'h00 |-> group_event_out_n)
      else $error("event out without enabled source");

   // Further checks on fields, flags, sequencing and the bus
   a_hi_bits_zero: assert property (
      pready && psel && !pwrite && paddr == ad_ctrl |-> prdata[7:6] == 2'h0)
      else $error("control high bits not zero");

   a_trig_bit_zero: assert property (
      pready && psel && !pwrite && paddr == ad_ctrl |-> !prdata[5])
      else $error("trigger bit read nonzero");

   a_redirect_stay: assert property (
      s_reg.fsm == SS_RUN && trig && s_reg.redirect |=> s_reg.fsm == SS_RUN)
      else $error("redirect left run state");

   a_redirect_no_off: assert property (
      s_reg.fsm == SS_RUN && trig && s_reg.redirect |=> !power_supply_on_n_oe)
      else $error("redirect released supply");

   a_flag_any_state: assert property (
      trig && s_reg.fsm != SS_RUN |=> s_reg.sts7[5])
      else $error("flag not set outside run");

   a_zero_no_wait: assert property (
      s_reg.fsm == SS_RUN && wr && paddr == ad_ctrl && !pwdata[5] |=> s_reg.fsm == SS_RUN)
      else $error("zero trigger started sleep");

   a_w1c_keep: assert property (
      wr && paddr == ad_sts && !pwdata[1] && s_reg.sts7[1] |=> s_reg.sts7[1])
      else $error("status bit lost on zero write");

   a_flag_w1c: assert property (
      wr && paddr == ad_sts && pwdata[5] |=> !s_reg.sts7[5])
      else $error("sleep flag not cleared by one");

   a_gpio_latch: assert property (
      ev_rise[3:0] != 4'h0 |=> (s_reg.sts7[3:0] & $past(ev_rise[3:0])) == $past(ev_rise[3:0]))
      else $error("gpio event not latched");

   a_no_spur_latch: assert property (
      !ev_rise[2] && !s_reg.sts7[2] |=> !s_reg.sts7[2])
      else $error("status bit set without edge");

   a_flag_only_trig: assert property (
      !trig && !s_reg.sts7[5] |=> !s_reg.sts7[5])
      else $error("sleep flag set without trigger");

   a_en_store: assert property (
      wr && paddr == ad_en |=> s_reg.en7 == $past(pwdata[5:0]))
      else $error("enable not stored");

   a_evt_source: assert property (
      (s_reg.sts7 & s_reg.en7) != 6'h00 |-> !group_event_out_n)
      else $error("enabled source without event out");

   a_evt_redirect: assert property (
      s_reg.redir_pend |-> !group_event_out_n)
      else $error("pending redirect without event out");

   a_reset_vals: assert property (
      $rose(presetn) |-> s_reg.slp_type == RST_SLP_TYPE && s_reg.sts7 == RST_STS_SEVEN)
      else $error("registers not zero after reset");

   a_reset_outs: assert property (
      $rose(presetn) |-> group_event_out_n && !power_supply_on_n_oe && !pready)
      else $error("outputs not idle after reset");

   a_ready_pulse: assert property (
      pready |=> !pready)
      else $error("ready stood two cycles");

   a_ready_after_setup: assert property (
      psel && !penable |=> pready)
      else $error("no ready after setup");

   a_rdata_idle: assert property (
      !pready |-> prdata == 32'h0000_0000)
      else $error("read data outside access");

   a_err_with_ready: assert property (
      pslverr |-> pready)
      else $error("error without ready");

   a_oe_stays: assert property (
      power_supply_on_n_oe |=> power_supply_on_n_oe)
      else $error("supply driven again after off");

   a_oe_only_off: assert property (
      power_supply_on_n_oe |-> s_reg.fsm == SS_OFF)
      else $error("supply floated outside off");

   a_wait_from_deep: assert property (
      s_reg.fsm == SS_WAIT && $past(s_reg.fsm) == SS_RUN |-> $past(trig) && $past(deep))
      else $error("wait entered without deep trigger");

   a_enter_cnt: assert property (
      s_reg.fsm == SS_RUN && trig && deep && !s_reg.redirect |=> s_reg.rtc_cnt == 2'h0)
      else $error("edge count not cleared on entry");

   a_wait_hold: assert property (
      s_reg.fsm == SS_WAIT && !rtc_rise |=> s_reg.fsm == SS_WAIT)
      else $error("wait left without rtc edge");

   a_wait_bounded: assert property (
      s_reg.fsm == SS_RUN ##1 s_reg.fsm == SS_WAIT |-> ##[1:WAIT_MAX_CYC] s_reg.fsm == SS_OFF)
      else $error("off not reached within two rtc periods");

   a_wait_min: assert property (
      s_reg.fsm == SS_RUN ##1 s_reg.fsm == SS_WAIT |-> ##300 s_reg.fsm == SS_WAIT)
      else $error("off reached before one rtc period");

   a_irq_off_set: assert property (
      s_reg.fsm == SS_WAIT ##1 s_reg.fsm == SS_OFF |-> s_reg.int_sts[1])
      else $error("off interrupt status not set");

   a_irq_trig: assert property (
      trig |=> s_reg.int_sts[0])
      else $error("trigger interrupt status not set");

   a_ist_rd_clear: assert property (
      rd && paddr == ad_ists && s_reg.prdata[0] |=> !s_reg.int_sts[0])
      else $error("interrupt status not cleared by read");

   a_type_stable: assert property (
      !(wr && paddr == ad_ctrl) |=> $stable(s_reg.slp_type))
      else $error("sleep type changed without write");

   a_mask_store: assert property (
      wr && paddr == ad_imask |=> s_reg.int_mask == $past(pwdata[1:0]))
      else $error("interrupt mask not stored");

   c_deep_off: cover property (s_reg.fsm == SS_WAIT ##[1:1000] s_reg.fsm == SS_OFF);
   c_redirect: cover property (trig && s_reg.redirect);
   c_shallow: cover property (trig && !deep);
   c_flag_clear: cover property (wr && paddr == ad_sts && pwdata[5]);
   c_event_out: cover property (ev_rise[0] && s_reg.en7[0] ##2 !group_event_out_n);
endmodule

/* File: verif/ssc_supply_model.sv */
// Far side: free-running 32 kHz RTC clock and the board's supply-on line.
// Assumes an open-drain supply-on pin with a pull-up on the board.
`timescale 1ns/1ps
module ssc_supply_model
   import ssc_pkg::*;
(
   output logic rtc_clk,
   input wire logic drive_low,
   input wire logic oe,
   output logic supply_on_n
);
   // RTC runs free; the offset keeps its phase unrelated to pclk
   initial begin
      rtc_clk = 1'b0;
      #7;
      forever #(RTC_PERIOD_NS / 2) rtc_clk = ~rtc_clk;
   end

   // Pull-up takes the released line to its inactive high level
   assign supply_on_n = oe ? 1'b1 : drive_low;
endmodule

/* File: verif/tb_ssc_top.sv */
// Self-checking bench for the sleep control and group-seven event block.
// Assumes the supply model for the RTC clock and the pulled-up supply line.
`timescale 1ns/1ps
module tb_ssc_top
   import ssc_pkg::*;
;
   localparam logic [11:0] A_CTRL = {IDX_SLEEP_CTRL, 2'b00};
   localparam logic [11:0] A_STS = {IDX_STS_SEVEN, 2'b00};
   localparam logic [11:0] A_EN = {IDX_EN_SEVEN, 2'b00};
   localparam logic [11:0] A_SUP = {IDX_SUPPLY_CTRL, 2'b00};
   localparam logic [11:0] A_IST = {IDX_INT_STS, 2'b00};
   localparam logic [11:0] A_IMSK = {IDX_INT_MASK, 2'b00};
   localparam int OFF_SLACK = 6; // Sync flops, edge detect and output register
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [4:0] ev = 5'h00;
   logic [31:0] prdata, rd;
   logic pready, pslverr, rtc_clk, ps_out, ps_oe, ev_n, irq, sup, er;
   int miscompares = 0;
   int checks = 0;

   // 10 MHz clock
   always #50 pclk = ~pclk;

   ssc_top u_ssc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .rtc_clk_in(rtc_clk), .gpio_event_in0(ev[0]),
      .gpio_event_in1(ev[1]), .gpio_event_in2(ev[2]), .gpio_event_in3(ev[3]),
      .keyboard_port_event_in(ev[4]), .power_supply_on_n_out(ps_out),
      .power_supply_on_n_oe(ps_oe), .group_event_out_n(ev_n), .irq(irq));

   ssc_supply_model u_ssc_supply_model (.rtc_clk(rtc_clk), .drive_low(ps_out), .oe(ps_oe),
      .supply_on_n(sup));

   // Verdict and end of run, shared with the watchdog
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic chk_b(input logic got, input logic exp, input string m);
      chk_w({31'h0, got}, {31'h0, exp}, m);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One APB transfer; request held until pready is seen at an edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk_b(n < 20, 1'b1, "pready timeout");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
      xfer(1'b0, a, 32'h0);
      chk_w(rd, e, m);
   endtask

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   task automatic t_reset();
      rdc(A_CTRL, 32'h0, "ctrl reset");
      rdc(A_STS, 32'h0, "status reset");
      chk_b(sup, 1'b0, "supply on");
      chk_b(ev_n, 1'b1, "event idle");
      $display("test reset done");
   endtask

   // Every field written, trigger left clear
   task automatic t_fields();
      wr(A_CTRL, 32'h0000_00df);
      rdc(A_CTRL, 32'h1c, "ctrl readback");
      idle(4);
      rdc(A_STS, 32'h0, "zero trigger flag");
      chk_b(ps_oe, 1'b0, "zero trigger off");
      xfer(1'b0, 12'h000, 32'h0);
      chk_b(er, 1'b1, "unmapped error");
      $display("test fields done");
   endtask

   // Shallow types only raise the flag; W1C clears it
   task automatic t_types();
      for (int t = 0; t < 6; t++) begin
         wr(A_CTRL, {26'h0, 1'b1, t[2:0], 2'b00});
         idle(4);
         rdc(A_STS, 32'h20, "sleep write flag");
         wr(A_STS, 32'h0);
         rdc(A_STS, 32'h20, "write zero keeps");
         wr(A_STS, 32'h20);
         rdc(A_STS, 32'h0, "write one clears");
      end
      idle(700);
      chk_b(ps_oe, 1'b0, "shallow no off");
      $display("test types done");
   endtask

   task automatic t_events();
      for (int i = 0; i < 5; i++) begin
         ev[i] <= 1'b1;
         idle(8);
         rdc(A_STS, 32'h1 << i, "pin latched");
         chk_b(ev_n, 1'b1, "masked source");
         wr(A_EN, 32'h1 << i);
         idle(3);
         chk_b(ev_n, 1'b0, "enabled source");
         wr(A_STS, 32'h1 << i);
         idle(3);
         chk_b(ev_n, 1'b1, "cleared source");
         ev[i] <= 1'b0;
         wr(A_EN, 32'h0);
      end
      $display("test events done");
   endtask

   // Deep type with redirect set: event instead of off
   task automatic t_redirect();
      wr(A_SUP, 32'h1);
      wr(A_CTRL, 32'h3c);
      idle(700);
      chk_b(ps_oe, 1'b0, "redirect no off");
      chk_b(ev_n, 1'b0, "redirect event");
      rdc(A_STS, 32'h20, "redirect flag");
      wr(A_STS, 32'h20);
      wr(A_SUP, 32'h0);
      idle(3);
      chk_b(ev_n, 1'b1, "redirect released");
      $display("test redirect done");
   endtask

   task automatic t_irq();
      wr(A_IMSK, 32'h1);
      wr(A_CTRL, 32'h20);
      idle(3);
      chk_b(irq, 1'b1, "irq raised");
      rdc(A_IST, 32'h1, "irq status");
      idle(3);
      chk_b(irq, 1'b0, "irq cleared by read");
      wr(A_IMSK, 32'h0);
      wr(A_CTRL, 32'h20);
      idle(3);
      chk_b(irq, 1'b0, "irq masked");
      rdc(A_IST, 32'h1, "masked status kept");
      wr(A_STS, 32'h20);
      $display("test irq done");
   endtask

   // Deep type: supply released 1 to 2 RTC periods after the trigger
   task automatic t_off(input logic [2:0] code);
      int n;
      do_reset();
      wr(A_CTRL, {26'h0, 1'b1, code, 2'b00});
      n = 0;
      while (ps_oe !== 1'b1 && n < 1000) begin
         @(posedge pclk);
         n++;
      end
      chk_b(n >= RTC_MIN_CYC && n <= RTC_MAX_CYC + OFF_SLACK, 1'b1, "off delay");
      chk_b(sup, 1'b1, "supply floated");
      rdc(A_IST, 32'h3, "off irq status");
      $display("test off done");
   endtask

   // Watchdog, well beyond the expected few thousand cycles
   initial begin
      #(20000 * 100);
      miscompares++;
      $display("Error at %0t: watchdog expired", $time);
      wrap_up();
   end

   // Main sequence
   initial begin
      do_reset();
      t_reset();
      t_fields();
      t_types();
      t_events();
      t_redirect();
      t_irq();
      t_off(SLP_TYPE_S4);
      t_off(SLP_TYPE_S5);
      wrap_up();
   end
endmodule
